//--- rtl/thm_pkg.sv
// Purpose: shared constants, carriers and decode helpers for the threshold monitor
// Assumes: measured values are unsigned; pressure is in 0.1 hPa, radiation in W/m2
// Notes: table lookups are functions so both channels decode settings the same way
package thm_pkg;
    // clock and seconds tick
    localparam int CLK_HZ = 200_000_000;
    localparam int SEC_TICK_S = 1;
    localparam int TICK_CYCLES_DFLT = SEC_TICK_S * CLK_HZ;
    // internal threshold steps, in measurement units (W/m2 on channel 1, 0.1 hPa on channel 2)
    localparam logic [15:0] THR_BASE = 16'h012c;
    localparam logic [15:0] THR_STEP = 16'h0064;
    localparam logic [3:0] THR_SEL_MAX = 4'ha;
    // 8-bit external threshold is percent of a 1300 upper range value
    localparam logic [15:0] PCT_SCALE = 16'h000d;
    // threshold source codes
    localparam logic [1:0] EXT_NONE = 2'h0;
    localparam logic [1:0] EXT_16 = 2'h1;
    localparam logic [1:0] EXT_8 = 2'h2;
    // activation modes from the first code to below the second silence the secondary crossing, from the second code up only the primary one
    localparam logic [3:0] MODE_SEC_SILENT = 4'h4;
    localparam logic [3:0] MODE_PRIM_SILENT = 4'h8;
    // cyclic period unit and factor ceiling
    localparam logic [10:0] CYC_UNIT_S = 11'h00a;
    localparam logic [6:0] CYC_FACTOR_MAX = 7'h78;
    // hysteresis table selectors
    localparam int HYST_RAD = 0;
    localparam int HYST_PRES = 1;
    // reset value of the accepted state
    localparam logic STATE_RST = 1'b0;

    typedef struct packed {
        logic [3:0] act_mode;
        logic [3:0] thr_sel;
        logic [2:0] hyst_sel;
        logic [1:0] ext_src;
        logic [3:0] on_dly;
        logic [3:0] off_dly;
        logic soc_en;
        logic [6:0] cyc_factor;
    } thm_cfg_t;

    typedef struct packed {
        logic wr16;
        logic [15:0] val16;
        logic wr8;
        logic [7:0] val8;
    } thm_ext_t;

    typedef enum logic [1:0] {
        THM_IDLE = 2'b01,
        THM_WAIT = 2'b10
    } thm_dly_st_t;

    // internal threshold: 300 + 100 * sel, sel clamped to 10
    function automatic logic [15:0] thm_int_thr(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > THR_SEL_MAX) ? THR_SEL_MAX : sel;
        return 16'(THR_BASE + THR_STEP * {12'h000, s});
    endfunction

    // hysteresis in measurement units for the given table
    function automatic logic [15:0] thm_hyst(input int kind, input logic [2:0] sel);
        logic [15:0] h;
        h = 16'h0000;
        if (kind == HYST_RAD) begin
            case (sel)
                3'h1: h = 16'h0096;
                3'h2: h = 16'h00c8;
                3'h3: h = 16'h00fa;
                default: h = 16'h0000;
            endcase
        end else begin
            case (sel)
                3'h1: h = 16'h0003;
                3'h2: h = 16'h0005;
                3'h3: h = 16'h000a;
                3'h4: h = 16'h001e;
                3'h5: h = 16'h0032;
                default: h = 16'h0000;
            endcase
        end
        return h;
    endfunction

    // delay choice to seconds
    function automatic logic [11:0] thm_dly_s(input logic [3:0] sel);
        case (sel)
            4'h1: return 12'h001;
            4'h2: return 12'h003;
            4'h3: return 12'h005;
            4'h4: return 12'h00a;
            4'h5: return 12'h00f;
            4'h6: return 12'h01e;
            4'h7: return 12'h03c;
            4'h8: return 12'h0b4;
            4'h9: return 12'h12c;
            4'ha: return 12'h258;
            4'hb: return 12'h384;
            4'hc: return 12'h708;
            4'hd: return 12'he10;
            default: return 12'h000;
        endcase
    endfunction
endpackage

//--- rtl/thm_monitor.sv
// Purpose: two-channel limit monitor with hysteresis, delays and telegram requests
// Assumes: all inputs come from logic on SYS_CLK_I; configuration changes rarely
// Notes: a send pulse carries the value to transmit; bus framing lives elsewhere
`timescale 1ns/10ps

module thm_channel #(
    parameter int MEAS_W = 16,
    parameter int HYST_KIND = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic tick_i,
    input wire logic [MEAS_W-1:0] meas_i,
    input wire thm_pkg::thm_cfg_t cfg_i,
    input wire thm_pkg::thm_ext_t ext_i,
    output logic state_o,
    output logic send_o,
    output logic send_val_o
);
    import thm_pkg::*;

    if (MEAS_W < 8 || MEAS_W > 16) begin : g_bad_width
        $error("thm_channel: MEAS_W must be 8..16");
    end

    logic prim_exceed, prim_val, prim_silent, sec_silent;
    logic ext_got_reg;
    logic [15:0] ext_thr_reg, thr;
    logic signed [17:0] meas_s, thr_s, hyst_s, hi_lim, lo_lim;
    logic zone_reg, enter, leave, raw;
    thm_dly_st_t st_reg;
    logic [11:0] tmr_reg, dly_s;
    logic state_reg, accept, new_silent, silent_now;
    logic [6:0] fac;
    logic [10:0] period, cyc_cnt_reg;
    logic cyc_due;

    // mode decode: bit1 picks crossing kind, bit0 picks polarity
    assign prim_exceed = ~cfg_i.act_mode[1];
    assign prim_val = ~cfg_i.act_mode[0];
    assign prim_silent = cfg_i.act_mode >= MODE_PRIM_SILENT;
    assign sec_silent = (cfg_i.act_mode >= MODE_SEC_SILENT) && !prim_silent;

    // external threshold capture; only the selected width is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_got_reg <= 1'b0;
            ext_thr_reg <= 16'h0000;
        end else if (ext_i.wr16 && cfg_i.ext_src == EXT_16) begin
            ext_got_reg <= 1'b1;
            ext_thr_reg <= ext_i.val16;
        end else if (ext_i.wr8 && cfg_i.ext_src == EXT_8) begin
            ext_got_reg <= 1'b1;
            ext_thr_reg <= 16'({8'h00, ext_i.val8} * PCT_SCALE);
        end
    end

    // until something arrives the internal setting keeps the channel useful
    assign thr = (cfg_i.ext_src != EXT_NONE && ext_got_reg) ? ext_thr_reg
                                                            : thm_int_thr(cfg_i.thr_sel);
    assign meas_s = 18'(meas_i);
    assign thr_s = 18'(thr);
    assign hyst_s = 18'(thm_hyst(HYST_KIND, cfg_i.hyst_sel));
    // signed limits so thr-hyst below zero cannot wrap
    assign hi_lim = 18'(thr_s + hyst_s);
    assign lo_lim = 18'(thr_s - hyst_s);
    assign enter = prim_exceed ? (meas_s > thr_s) : (meas_s < thr_s);
    assign leave = prim_exceed ? (meas_s < lo_lim) : (meas_s > hi_lim);

    // hysteresis zone: 1 while in the primary crossing's region
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            zone_reg <= 1'b0;
        end else if (!zone_reg && enter) begin
            zone_reg <= 1'b1;
        end else if (zone_reg && leave) begin
            zone_reg <= 1'b0;
        end
    end

    assign raw = zone_reg ? prim_val : ~prim_val;
    assign dly_s = raw ? thm_dly_s(cfg_i.on_dly) : thm_dly_s(cfg_i.off_dly);
    assign accept = (raw != state_reg) &&
                    (((st_reg == THM_IDLE) && (dly_s == 12'h000)) ||
                     ((st_reg == THM_WAIT) && tick_i && (12'(tmr_reg + 12'h001) >= dly_s)));

    // delay fsm: the old state stays visible until the delay runs out
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            st_reg <= THM_IDLE;
            tmr_reg <= 12'h000;
            state_reg <= STATE_RST;
        end else begin
            case (st_reg)
                THM_IDLE: begin
                    if (accept) begin
                        state_reg <= raw;
                    end else if (raw != state_reg) begin
                        st_reg <= THM_WAIT;
                        tmr_reg <= 12'h000;
                    end
                end
                THM_WAIT: begin
                    if (raw == state_reg) begin
                        st_reg <= THM_IDLE; // bounced back, nothing to accept
                    end else if (accept) begin
                        state_reg <= raw;
                        st_reg <= THM_IDLE;
                    end else if (tick_i) begin
                        tmr_reg <= 12'(tmr_reg + 12'h001);
                    end
                end
                default: st_reg <= THM_IDLE;
            endcase
        end
    end

    assign state_o = state_reg;
    assign new_silent = (raw == prim_val) ? prim_silent : sec_silent;
    assign silent_now = (state_reg == prim_val) ? prim_silent : sec_silent;
    assign fac = (cfg_i.cyc_factor > CYC_FACTOR_MAX) ? CYC_FACTOR_MAX : cfg_i.cyc_factor;
    assign period = 11'({4'h0, fac} * CYC_UNIT_S);
    assign cyc_due = tick_i && (fac != 7'h00) && (11'(cyc_cnt_reg + 11'h001) >= period);

    // cyclic timer in seconds; a zero factor parks it
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i || fac == 7'h00) begin
            cyc_cnt_reg <= 11'h000;
        end else if (cyc_due) begin
            cyc_cnt_reg <= 11'h000;
        end else if (tick_i) begin
            cyc_cnt_reg <= 11'(cyc_cnt_reg + 11'h001);
        end
    end

    // telegram request; a change send wins and already carries the new value
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            send_o <= 1'b0;
            send_val_o <= 1'b0;
        end else if (accept && cfg_i.soc_en && !new_silent) begin
            send_o <= 1'b1;
            send_val_o <= raw;
        end else if (cyc_due && !silent_now) begin
            send_o <= 1'b1;
            send_val_o <= state_reg;
        end else begin
            send_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !en_i);

    property p_enter_zone;
        !zone_reg && enter |=> zone_reg;
    endproperty
    a_enter_zone: assert property (p_enter_zone) else $error("zone not entered");

    property p_hold_zone;
        zone_reg && !leave |=> zone_reg;
    endproperty
    a_hold_zone: assert property (p_hold_zone) else $error("zone left inside band");

    property p_change_send;
        accept && cfg_i.soc_en && !new_silent |=> send_o && (send_val_o == $past(raw));
    endproperty
    a_change_send: assert property (p_change_send) else $error("change not sent");

    property p_no_soc;
        send_o |-> $past(cyc_due) || $past(cfg_i.soc_en);
    endproperty
    a_no_soc: assert property (p_no_soc) else $error("send without cause");

    property p_cyc_send;
        cyc_due && !silent_now && !accept |=> send_o && (send_val_o == $past(state_reg));
    endproperty
    a_cyc_send: assert property (p_cyc_send) else $error("cyclic send wrong");

    property p_silent;
        send_o |-> $past(accept) || !$past(silent_now);
    endproperty
    a_silent: assert property (p_silent) else $error("silent state sent");

    property p_no_delay;
        st_reg == THM_IDLE && raw != state_reg && dly_s == 12'h000 |=> state_reg == $past(raw);
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("zero delay not immediate");

    property p_hold_old;
        st_reg == THM_WAIT && !tick_i |=> state_reg == $past(state_reg);
    endproperty
    a_hold_old: assert property (p_hold_old) else $error("state moved without tick");

    property p_zero_factor;
        fac == 7'h00 |=> cyc_cnt_reg == 11'h000 ##0 !cyc_due;
    endproperty
    a_zero_factor: assert property (p_zero_factor) else $error("cyclic timer ran");

    property p_ext16;
        ext_i.wr16 && cfg_i.ext_src == EXT_16 |=> thr == $past(ext_i.val16);
    endproperty
    a_ext16: assert property (p_ext16) else $error("external value not used");
endmodule

module thm_monitor #(
    parameter int TICK_CYCLES = thm_pkg::TICK_CYCLES_DFLT
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic SENSOR_EN_I,
    input wire logic [1:0] LIMIT_SEL_I,
    input wire logic [15:0] MEAS_VALUE_I,
    input wire thm_pkg::thm_cfg_t CH1_CFG_I,
    input wire thm_pkg::thm_cfg_t CH2_CFG_I,
    input wire thm_pkg::thm_ext_t CH1_EXT_I,
    input wire thm_pkg::thm_ext_t CH2_EXT_I,
    output logic CH1_STATE_O,
    output logic CH1_SEND_O,
    output logic CH1_SEND_VAL_O,
    output logic CH2_STATE_O,
    output logic CH2_SEND_O,
    output logic CH2_SEND_VAL_O
);
    import thm_pkg::*;

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("thm_monitor: TICK_CYCLES must be at least 2");
    end

    localparam int DIV_W = $clog2(TICK_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    logic [DIV_W-1:0] div_reg;
    logic tick_reg, ch1_en_reg, ch2_en_reg;

    // seconds tick as a one-cycle enable
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == DIV_LAST);
            div_reg <= (div_reg == DIV_LAST) ? '0 : DIV_W'(div_reg + 1'b1);
        end
    end

    // channel enables registered; a disabled channel is held cleared except for its captured external threshold
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ch1_en_reg <= 1'b0;
            ch2_en_reg <= 1'b0;
        end else begin
            ch1_en_reg <= SENSOR_EN_I && (LIMIT_SEL_I != 2'h0);
            ch2_en_reg <= SENSOR_EN_I && (LIMIT_SEL_I == 2'h2);
        end
    end

    // one module, two instances with their own tables
    thm_channel #(.MEAS_W(16), .HYST_KIND(HYST_RAD)) u_ch1 (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .en_i(ch1_en_reg),
        .tick_i(tick_reg),
        .meas_i(MEAS_VALUE_I),
        .cfg_i(CH1_CFG_I),
        .ext_i(CH1_EXT_I),
        .state_o(CH1_STATE_O),
        .send_o(CH1_SEND_O),
        .send_val_o(CH1_SEND_VAL_O)
    );

    thm_channel #(.MEAS_W(16), .HYST_KIND(HYST_PRES)) u_ch2 (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .en_i(ch2_en_reg),
        .tick_i(tick_reg),
        .meas_i(MEAS_VALUE_I),
        .cfg_i(CH2_CFG_I),
        .ext_i(CH2_EXT_I),
        .state_o(CH2_STATE_O),
        .send_o(CH2_SEND_O),
        .send_val_o(CH2_SEND_VAL_O)
    );
endmodule

//--- test/thm_bus_model.sv
// Purpose: far side of the monitor: telegram sink and external threshold transmitter
// Assumes: send requests are one-cycle pulses sampled on the rising clock edge
// Notes: spacing of the last two telegrams is kept so cyclic periods can be measured
`timescale 1ns/10ps

module thm_bus_model (
    input wire logic clk_i,
    input wire logic [1:0] send_i,
    input wire logic [1:0] val_i,
    output thm_pkg::thm_ext_t ext1_o
);
    import thm_pkg::*;
    int n [2] = '{0, 0};
    logic v [2];
    int p [2] = '{0, 0};
    int t [2] = '{0, 0};
    int cyc = 0;

    initial begin
        ext1_o = '0;
    end

    // telegram sink: count requests, keep value and spacing in cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 2; i++) begin
            if (send_i[i]) begin
                n[i] <= n[i] + 1;
                v[i] <= val_i[i];
                p[i] <= cyc - t[i];
                t[i] <= cyc;
            end
        end
    end

    // one-cycle object write; released data is inverted so stale values never match
    task automatic put16(input logic [15:0] d);
        @(negedge clk_i);
        ext1_o.val16 = d;
        ext1_o.wr16 = 1'b1;
        @(negedge clk_i);
        ext1_o.wr16 = 1'b0;
        ext1_o.val16 = ~d;
    endtask

    task automatic put8(input logic [7:0] d);
        @(negedge clk_i);
        ext1_o.val8 = d;
        ext1_o.wr8 = 1'b1;
        @(negedge clk_i);
        ext1_o.wr8 = 1'b0;
        ext1_o.val8 = ~d;
    endtask
endmodule

//--- test/tb.sv
// Purpose: self-checking bench for the two-channel limit monitor
// Assumes: seconds tick shortened to 10 cycles, so 1 s is 10 clocks
// Notes: telegrams are counted by the bus model; checks use count deltas
`timescale 1ns/10ps

module tb;
    import thm_pkg::*;
    localparam int TK = 10;
    logic clk, rst, sen;
    logic [1:0] lsel;
    logic [15:0] meas;
    thm_cfg_t c1, c2;
    thm_ext_t e1;
    logic s1, s1v, s2, s2v, st1, st2;
    int mismatches, n_tests, b;

    thm_monitor #(.TICK_CYCLES(TK)) u_thm_monitor (
        .SYS_CLK_I(clk), .RST_I(rst), .SENSOR_EN_I(sen), .LIMIT_SEL_I(lsel),
        .MEAS_VALUE_I(meas), .CH1_CFG_I(c1), .CH2_CFG_I(c2), .CH1_EXT_I(e1),
        .CH2_EXT_I('0), .CH1_STATE_O(st1), .CH1_SEND_O(s1), .CH1_SEND_VAL_O(s1v),
        .CH2_STATE_O(st2), .CH2_SEND_O(s2), .CH2_SEND_VAL_O(s2v)
    );

    thm_bus_model u_thm_bus_model (
        .clk_i(clk), .send_i({s2, s1}), .val_i({s2v, s1v}), .ext1_o(e1)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_b(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_n(input int g, input int e);
        n_tests++;
        if (g != e) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    function automatic thm_cfg_t mk(logic [3:0] m, logic [3:0] t, logic [2:0] h,
            logic [1:0] x, logic [3:0] on, logic [3:0] off, logic s, logic [6:0] y);
        return '{m, t, h, x, on, off, s, y};
    endfunction

    function automatic logic st(input int ch);
        return ch ? st2 : st1;
    endfunction

    // reset with a fresh channel 1 setup; hold 3 cycles
    task automatic restart(input thm_cfg_t a, input logic [15:0] m);
        rst = 1'b1;
        c1 = a;
        meas = m;
        step(3);
        rst = 1'b0;
        step(2);
    endtask

    // new measurement; state settles two edges later, telegrams counted
    task automatic put(input int ch, input logic [15:0] m, input logic es, input int dn);
        int n0;
        n0 = u_thm_bus_model.n[ch];
        meas = m;
        step(4);
        chk_b(st(ch), es);
        chk_n(u_thm_bus_model.n[ch] - n0, dn);
        if (dn > 0) chk_b(u_thm_bus_model.v[ch], es);
    endtask

    // bounded waits; running out is a failure
    task automatic wait_st(input int ch, input logic e, input int lim);
        int k;
        k = 0;
        while (st(ch) !== e && k < lim) begin
            step(1);
            k++;
        end
        // judge by the awaited condition so a hit on the last step still counts
        if (st(ch) !== e) begin
            mismatches++;
            end_sim();
        end
    endtask

    task automatic wait_n(input int ch, input int target, input int lim);
        int k;
        k = 0;
        while (u_thm_bus_model.n[ch] < target && k < lim) begin
            step(1);
            k++;
        end
        if (u_thm_bus_model.n[ch] < target) begin
            mismatches++;
            end_sim();
        end
    endtask

    initial begin
        mismatches = 0;
        n_tests = 0;
        rst = 1'b1;
        sen = 1'b1;
        lsel = 2'h1;
        meas = 16'h0000;
        c1 = mk(4'h0, 4'h0, 3'h1, 2'h0, 4'h0, 4'h0, 1'b1, 7'h00);
        c2 = mk(4'h0, 4'ha, 3'h5, 2'h0, 4'h0, 4'h0, 1'b1, 7'h00);
        step(3);
        rst = 1'b0;
        step(2);
        // second channel: idle with one limit, 1300 threshold and 5 hPa band with two
        put(1, 16'h0515, 1'b0, 0);
        lsel = 2'h2;
        put(1, 16'h0515, 1'b1, 1);
        put(1, 16'h04e2, 1'b1, 0);
        put(1, 16'h04e1, 1'b0, 1);
        // exceed mode, 300 with 150 band, boundaries included
        restart(c1, 16'h0000);
        put(0, 16'h012c, 1'b0, 0);
        put(0, 16'h012d, 1'b1, 1);
        put(0, 16'h0096, 1'b1, 0);
        put(0, 16'h0095, 1'b0, 1);
        // undershoot mode
        restart(mk(4'h2, 4'h0, 3'h1, 2'h0, 4'h0, 4'h0, 1'b1, 7'h00), 16'h03e8);
        put(0, 16'h012b, 1'b1, 1);
        put(0, 16'h01c2, 1'b1, 0);
        put(0, 16'h01c3, 1'b0, 1);
        // undershoot side silent: no cyclic in that state, change sent only upward
        restart(mk(4'h4, 4'h0, 3'h0, 2'h0, 4'h0, 4'h0, 1'b1, 7'h01), 16'h0000);
        b = u_thm_bus_model.n[0];
        step(250);
        chk_n(u_thm_bus_model.n[0] - b, 0);
        put(0, 16'h012d, 1'b1, 1);
        wait_n(0, b + 3, 250);
        // factor 1 gives one 10 s unit, TK clocks per second
        chk_n(u_thm_bus_model.p[0], int'(CYC_UNIT_S) * TK);
        put(0, 16'h0000, 1'b0, 0);
        // change sending off, cyclic off: silence
        restart(mk(4'h0, 4'h0, 3'h0, 2'h0, 4'h0, 4'h0, 1'b0, 7'h00), 16'h0000);
        b = u_thm_bus_model.n[0];
        put(0, 16'h012d, 1'b1, 0);
        step(300);
        chk_n(u_thm_bus_model.n[0] - b, 0);
        // 60 s delays with 10 s cyclic: old value keeps being sent
        restart(mk(4'h0, 4'h0, 3'h0, 2'h0, 4'h7, 4'h7, 1'b1, 7'h01), 16'h0000);
        b = u_thm_bus_model.n[0];
        meas = 16'h012d;
        step(500);
        chk_b(st1, 1'b0);
        chk_b(u_thm_bus_model.v[0], 1'b0);
        chk_b(logic'(u_thm_bus_model.n[0] - b >= 4), 1'b1);
        wait_st(0, 1'b1, 200);
        step(2);
        chk_b(u_thm_bus_model.v[0], 1'b1);
        meas = 16'h0000;
        step(500);
        chk_b(st1, 1'b1);
        chk_b(u_thm_bus_model.v[0], 1'b1);
        wait_st(0, 1'b0, 200);
        step(2);
        chk_b(u_thm_bus_model.v[0], 1'b0);
        // external 16-bit threshold 500 replaces internal 300
        restart(mk(4'h0, 4'h0, 3'h0, 2'h1, 4'h0, 4'h0, 1'b1, 7'h00), 16'h0000);
        u_thm_bus_model.put16(16'h01f4);
        put(0, 16'h0190, 1'b0, 0);
        put(0, 16'h01f5, 1'b1, 1);
        // external 8-bit: 50 percent of 1300 is 650; a 2-byte write is ignored
        restart(mk(4'h0, 4'h0, 3'h0, 2'h2, 4'h0, 4'h0, 1'b1, 7'h00), 16'h0000);
        u_thm_bus_model.put8(8'h32);
        u_thm_bus_model.put16(16'h0000);
        put(0, 16'h0280, 1'b0, 0);
        put(0, 16'h028b, 1'b1, 1);
        // inverted polarity, exceeding silent: state goes from reset 0 to 1 with a telegram, rise sends nothing
        restart(mk(4'h9, 4'h0, 3'h0, 2'h0, 4'h0, 4'h0, 1'b1, 7'h00), 16'h0000);
        put(0, 16'h0000, 1'b1, 1);
        put(0, 16'h012d, 1'b0, 0);
        put(0, 16'h0000, 1'b1, 1);
        // sensor off holds the channel idle
        restart(mk(4'h0, 4'h0, 3'h0, 2'h0, 4'h0, 4'h0, 1'b1, 7'h00), 16'h0000);
        sen = 1'b0;
        put(0, 16'h012d, 1'b0, 0);
        end_sim();
    end
endmodule
